// File: logic/btcc_cell.sv
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module btcc_cell (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic TCK,
  input wire logic TDI,
  input wire logic SHIFT,
  input wire logic UPDATE,
  input wire logic MODE,
  input wire logic LATCH_PRESET_N,
  input wire logic TEST_CLOCK_GATE,
  input wire logic PARALLEL_IN,
  output logic PARALLEL_OUT,
  output logic TDO,
  output logic HELD_CONTROL_BIT,
  input btcc_pkg::btcc_bus_t BUS,
  output logic [btcc_pkg::DATA_W-1:0] RDATA
);
  import btcc_pkg::*;

  logic [CTRL_W-1:0] ctrl_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [STRETCH_W-1:0] stretch_q;
  logic tck_rst_n_q;
  logic sys_in;
  logic rst_t1_q, rst_t2_q;
  logic sys_t1_q, sys_t2_q;
  logic cap_q;
  logic held;
  logic held_s1_q, held_s2_q;
  logic tdo_s1_q, tdo_s2_q;
  logic gate_seen_q;

  // Software may replace the core's control signal, e.g. to test the pad path.
  assign sys_in = ctrl_q[CTRL_SEL_BIT] ? ctrl_q[CTRL_VAL_BIT] : PARALLEL_IN;

  // The parallel path is purely combinational so that the pad never waits for a clock.
  assign PARALLEL_OUT = MODE ? held : sys_in;
  assign TDO = cap_q;
  assign HELD_CONTROL_BIT = held;
  assign RDATA = rdata_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_q <= CTRL_RESET;
    end else if (BUS.wr && BUS.addr == CTRL_OFS) begin
      ctrl_q <= BUS.wdata[CTRL_W-1:0];
    end
  end

  // Read data is zero except in the one cycle after a read strobe.
  always_comb begin
    rdata_d = READ_ZERO;
    if (BUS.rd) begin
      if (BUS.addr == CTRL_OFS) begin
        rdata_d[CTRL_W-1:0] = ctrl_q;
      end else if (BUS.addr == STATUS_OFS) begin
        rdata_d[STAT_HELD_BIT] = held_s2_q;
        rdata_d[STAT_TDO_BIT] = tdo_s2_q;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_q <= READ_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Status bits come from the test clock side and are synchronised before use.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      held_s1_q <= 1'b0;
      held_s2_q <= 1'b0;
      tdo_s1_q <= 1'b0;
      tdo_s2_q <= 1'b0;
    end else begin
      held_s1_q <= held;
      held_s2_q <= held_s1_q;
      tdo_s1_q <= cap_q;
      tdo_s2_q <= tdo_s1_q;
    end
  end

  // The system reset is released into the test clock domain through two flops.
  // A short system reset may see no test clock edge at all.
  // The reset handed to the test clock side is therefore stretched here first.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      stretch_q <= RST_STRETCH;
      tck_rst_n_q <= 1'b0;
    end else begin
      if (stretch_q != STRETCH_DONE) begin
        stretch_q <= stretch_q - STRETCH_STEP;
      end
      tck_rst_n_q <= (stretch_q == STRETCH_DONE);
    end
  end

  always_ff @(posedge TCK) begin
    rst_t1_q <= tck_rst_n_q;
    rst_t2_q <= rst_t1_q;
  end

  always_ff @(posedge TCK) begin
    if (!rst_t2_q) begin
      sys_t1_q <= 1'b0;
      sys_t2_q <= 1'b0;
    end else begin
      sys_t1_q <= sys_in;
      sys_t2_q <= sys_t1_q;
    end
  end

  // Capture and shift share one flop; the gate freezes it entirely.
  always_ff @(posedge TCK) begin
    if (!rst_t2_q) begin
      cap_q <= 1'b0;
    end else if (TEST_CLOCK_GATE) begin
      cap_q <= SHIFT ? TDI : sys_t2_q;
    end
  end

  always_ff @(posedge TCK) begin
    if (!rst_t2_q) begin
      gate_seen_q <= 1'b0;
    end else begin
      gate_seen_q <= TEST_CLOCK_GATE;
    end
  end

  // Update latch: preset dominates, low update is transparent.
  always_latch begin
    if (!LATCH_PRESET_N) begin
      held <= PRESET_LEVEL;
    end else if (!UPDATE) begin
      held <= cap_q;
    end
  end

  property p_mode_low;
    @(posedge CLK) disable iff (!RST_N) !MODE |-> PARALLEL_OUT == sys_in;
  endproperty
  a_mode_low: assert property (p_mode_low) else $error("output does not follow system input");

  property p_mode_high;
    @(posedge CLK) disable iff (!RST_N) MODE |-> PARALLEL_OUT == HELD_CONTROL_BIT;
  endproperty
  a_mode_high: assert property (p_mode_high) else $error("output does not show held bit");

  property p_cap_par;
    @(posedge TCK) disable iff (!rst_t2_q)
      TEST_CLOCK_GATE && !SHIFT |=> TDO == $past(sys_t2_q);
  endproperty
  a_cap_par: assert property (p_cap_par) else $error("capture missed system input");

  property p_cap_ser;
    @(posedge TCK) disable iff (!rst_t2_q) TEST_CLOCK_GATE && SHIFT |=> TDO == $past(TDI);
  endproperty
  a_cap_ser: assert property (p_cap_ser) else $error("shift missed serial input");

  property p_gate_hold;
    @(posedge TCK) disable iff (!rst_t2_q) !TEST_CLOCK_GATE |=> $stable(TDO);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("serial output moved while gated");

  property p_neg_quiet;
    @(negedge TCK) disable iff (!rst_t2_q) $changed(TDO) |-> gate_seen_q;
  endproperty
  a_neg_quiet: assert property (p_neg_quiet) else $error("serial output moved without edge");

  property p_preset;
    @(posedge CLK) disable iff (!RST_N) !LATCH_PRESET_N |-> HELD_CONTROL_BIT == 1'b1;
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not force held bit");

  property p_transp;
    @(posedge CLK) disable iff (!RST_N) LATCH_PRESET_N && !UPDATE |-> HELD_CONTROL_BIT == TDO;
  endproperty
  a_transp: assert property (p_transp) else $error("latch not transparent");

  property p_hold;
    @(posedge CLK) disable iff (!RST_N)
      LATCH_PRESET_N && UPDATE && $past(LATCH_PRESET_N) && $past(UPDATE)
      |-> $stable(HELD_CONTROL_BIT);
  endproperty
  a_hold: assert property (p_hold) else $error("held bit changed while holding");

  // The pin path and the software path are checked against their own sources.
  property p_pin_path;
    @(posedge CLK) disable iff (!RST_N)
      !MODE && !ctrl_q[CTRL_SEL_BIT] |-> PARALLEL_OUT == PARALLEL_IN;
  endproperty
  a_pin_path: assert property (p_pin_path) else $error("output does not follow pin");

  property p_sw_path;
    @(posedge CLK) disable iff (!RST_N)
      !MODE && ctrl_q[CTRL_SEL_BIT] |-> PARALLEL_OUT == ctrl_q[CTRL_VAL_BIT];
  endproperty
  a_sw_path: assert property (p_sw_path) else $error("output does not follow software");

  property p_preset_out;
    @(posedge CLK) disable iff (!RST_N)
      MODE && !LATCH_PRESET_N |-> PARALLEL_OUT == PRESET_LEVEL;
  endproperty
  a_preset_out: assert property (p_preset_out) else $error("preset not on output");

  property p_preset_tck;
    @(posedge TCK) disable iff (!rst_t2_q)
      !LATCH_PRESET_N |-> HELD_CONTROL_BIT == PRESET_LEVEL;
  endproperty
  a_preset_tck: assert property (p_preset_tck) else $error("preset lost at test clock");

  property p_transp_tck;
    @(negedge TCK) disable iff (!rst_t2_q)
      LATCH_PRESET_N && !UPDATE |-> HELD_CONTROL_BIT == TDO;
  endproperty
  a_transp_tck: assert property (p_transp_tck) else $error("latch not following");

  property p_hold_tck;
    @(posedge TCK) disable iff (!rst_t2_q)
      LATCH_PRESET_N && UPDATE && $past(LATCH_PRESET_N) && $past(UPDATE) |-> $stable(held);
  endproperty
  a_hold_tck: assert property (p_hold_tck) else $error("held bit moved at test clock");

  property p_mode_high_tck;
    @(negedge TCK) disable iff (!rst_t2_q)
      MODE |-> PARALLEL_OUT == HELD_CONTROL_BIT;
  endproperty
  a_mode_high_tck: assert property (p_mode_high_tck) else $error("output lost held bit");

  property p_gate_rise;
    @(posedge TCK) disable iff (!rst_t2_q)
      $changed(TDO) |-> $past(TEST_CLOCK_GATE);
  endproperty
  a_gate_rise: assert property (p_gate_rise) else $error("serial output moved ungated");

  property p_gate_neg;
    @(negedge TCK) disable iff (!rst_t2_q)
      !gate_seen_q |-> $stable(TDO);
  endproperty
  a_gate_neg: assert property (p_gate_neg) else $error("serial output moved gated off");

  property p_status_tdo;
    @(posedge CLK) disable iff (!RST_N)
      BUS.rd && BUS.addr == STATUS_OFS |=> RDATA[STAT_TDO_BIT] == $past(tdo_s2_q);
  endproperty
  a_status_tdo: assert property (p_status_tdo) else $error("status serial bit wrong");

  property p_status_held;
    @(posedge CLK) disable iff (!RST_N)
      BUS.rd && BUS.addr == STATUS_OFS |=> RDATA[STAT_HELD_BIT] == $past(held_s2_q);
  endproperty
  a_status_held: assert property (p_status_held) else $error("status held bit wrong");

  property p_rdata_ctrl;
    @(posedge CLK) disable iff (!RST_N)
      BUS.rd && BUS.addr == CTRL_OFS |=> RDATA[CTRL_W-1:0] == $past(ctrl_q);
  endproperty
  a_rdata_ctrl: assert property (p_rdata_ctrl) else $error("control readback wrong");

  property p_rdata_unmapped;
    @(posedge CLK) disable iff (!RST_N)
      BUS.rd && BUS.addr != CTRL_OFS && BUS.addr != STATUS_OFS |=> RDATA == READ_ZERO;
  endproperty
  a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("unmapped read not zero");

  property p_rdata_quiet;
    @(posedge CLK) disable iff (!RST_N)
      !$past(BUS.rd) |-> RDATA == READ_ZERO;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data without read");

  property p_wr_ctrl;
    @(posedge CLK) disable iff (!RST_N)
      BUS.wr && BUS.addr == CTRL_OFS |=> ctrl_q == $past(BUS.wdata[CTRL_W-1:0]);
  endproperty
  a_wr_ctrl: assert property (p_wr_ctrl) else $error("control write lost");

  // The test clock side must be held in reset whenever the system is.
  property p_tck_rst;
    @(posedge CLK)
      !RST_N |=> !tck_rst_n_q;
  endproperty
  a_tck_rst: assert property (p_tck_rst) else $error("test clock reset not held");

  c_shift: cover property (@(posedge TCK) TEST_CLOCK_GATE && SHIFT ##1 TEST_CLOCK_GATE && SHIFT);
  c_update: cover property (@(posedge CLK) LATCH_PRESET_N && !UPDATE ##1 UPDATE && MODE);
  c_preset: cover property (@(posedge CLK) !LATCH_PRESET_N ##1 LATCH_PRESET_N && MODE);
  c_sw_drive: cover property (@(posedge CLK) ctrl_q[CTRL_SEL_BIT] && !MODE);
  c_follow: cover property (@(posedge TCK) LATCH_PRESET_N && !UPDATE && TEST_CLOCK_GATE);
endmodule

// File: logic/btcc_pkg.sv
package btcc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam int CTRL_SEL_BIT = 0;
  localparam int CTRL_VAL_BIT = 1;
  localparam int STAT_HELD_BIT = 0;
  localparam int STAT_TDO_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0;
  localparam logic PRESET_LEVEL = 1'b1;
  localparam int CTRL_W = 2;
  localparam int STRETCH_W = 5;
  localparam logic [STRETCH_W-1:0] RST_STRETCH = 5'h10;
  localparam logic [STRETCH_W-1:0] STRETCH_DONE = 5'h00;
  localparam logic [STRETCH_W-1:0] STRETCH_STEP = 5'h01;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } btcc_bus_t;
endpackage

// File: tb/btcc_tap_model.sv
`timescale 1ns/1ps
module btcc_tap_model (
  output logic TCK,
  output logic TDI,
  output logic SHIFT,
  output logic UPDATE,
  output logic LATCH_PRESET_N,
  output logic TEST_CLOCK_GATE
);
  initial begin
    {TCK, TDI, SHIFT, TEST_CLOCK_GATE} = 4'h0;
    {UPDATE, LATCH_PRESET_N} = 2'h2;
  end
  always #16 TCK = ~TCK;
  // Controls move after the falling edge so they are steady across the capturing rise.
  task automatic step(input logic g, input logic s, input logic d);
    @(negedge TCK);
    TEST_CLOCK_GATE <= g;
    SHIFT <= s;
    TDI <= d;
    @(posedge TCK);
    TEST_CLOCK_GATE <= 1'b0;
    #2;
  endtask
  task automatic ctl(input logic u, input logic p);
    @(negedge TCK);
    UPDATE <= u;
    LATCH_PRESET_N <= p;
    #2;
  endtask
endmodule

// File: tb/btcc_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module boundary_scan_tristate_ctrl_cell_tb_top;
  import btcc_pkg::*;
  logic CLK = 0;
  logic RST_N = 0;
  logic MODE = 0;
  logic PARALLEL_IN = 0;
  logic PARALLEL_OUT, TDO, HELD_CONTROL_BIT;
  logic TCK, TDI, SHIFT, UPDATE, LATCH_PRESET_N, TEST_CLOCK_GATE;
  btcc_bus_t BUS = '0;
  logic [DATA_W-1:0] RDATA;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  btcc_tap_model tap (.TCK(TCK), .TDI(TDI), .SHIFT(SHIFT), .UPDATE(UPDATE),
    .LATCH_PRESET_N(LATCH_PRESET_N), .TEST_CLOCK_GATE(TEST_CLOCK_GATE));
  btcc_cell dut_u (.CLK(CLK), .RST_N(RST_N), .TCK(TCK), .TDI(TDI), .SHIFT(SHIFT),
    .UPDATE(UPDATE), .MODE(MODE), .LATCH_PRESET_N(LATCH_PRESET_N),
    .TEST_CLOCK_GATE(TEST_CLOCK_GATE), .PARALLEL_IN(PARALLEL_IN),
    .PARALLEL_OUT(PARALLEL_OUT), .TDO(TDO), .HELD_CONTROL_BIT(HELD_CONTROL_BIT),
    .BUS(BUS), .RDATA(RDATA));
  always #5 CLK = ~CLK;
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge CLK);
    BUS.addr <= a;
    BUS.wdata <= d;
    BUS.wr <= 1'b1;
    @(posedge CLK);
    BUS.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
    @(posedge CLK);
    BUS.addr <= a;
    BUS.rd <= 1'b1;
    @(posedge CLK);
    BUS.rd <= 1'b0;
    #1;
    q = RDATA;
  endtask
  task automatic t_parallel();
    logic [DATA_W-1:0] d;
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK);
      PARALLEL_IN <= i[0];
      #1;
      `CHK(PARALLEL_OUT, i[0])
    end
    wr(CTRL_OFS, 32'h1);
    `CHK(PARALLEL_OUT, 1'b0)
    rd(CTRL_OFS, d);
    `CHK(d, 32'h1)
    rd(4'h8, d);
    `CHK(d, READ_ZERO)
    wr(CTRL_OFS, 32'h0);
  endtask
  task automatic t_shift();
    tap.step(1'b1, 1'b1, 1'b0);
    `CHK(TDO, 1'b0)
    tap.step(1'b0, 1'b1, 1'b1);
    tap.step(1'b0, 1'b0, 1'b1);
    `CHK(TDO, 1'b0)
    tap.ctl(1'b0, 1'b1);
    `CHK(HELD_CONTROL_BIT, 1'b0)
    @(posedge CLK);
    MODE <= 1'b1;
    #1;
    `CHK(PARALLEL_OUT, 1'b0)
    tap.ctl(1'b1, 1'b1);
    tap.step(1'b1, 1'b1, 1'b1);
    `CHK({TDO, HELD_CONTROL_BIT}, 2'h2)
    tap.ctl(1'b1, 1'b0);
    `CHK({HELD_CONTROL_BIT, PARALLEL_OUT}, 2'h3)
  endtask
  task automatic t_capture();
    logic [DATA_W-1:0] d;
    @(posedge CLK);
    PARALLEL_IN <= 1'b0;
    repeat (3) tap.step(1'b1, 1'b0, 1'b1);
    `CHK(TDO, 1'b0)
    repeat (3) @(posedge CLK);
    rd(STATUS_OFS, d);
    `CHK(d, 32'h1)
    wr(CTRL_OFS, 32'h3);
    repeat (3) tap.step(1'b1, 1'b0, 1'b0);
    `CHK(TDO, 1'b1)
  endtask
  task automatic t_chain();
    logic [DATA_W-1:0] d;
    tap.ctl(1'b1, 1'b1);
    `CHK(HELD_CONTROL_BIT, 1'b1)
    tap.step(1'b1, 1'b1, 1'b0);
    `CHK(TDO, 1'b0)
    tap.step(1'b1, 1'b1, 1'b1);
    `CHK({TDO, HELD_CONTROL_BIT}, 2'h3)
    tap.step(1'b1, 1'b1, 1'b0);
    `CHK({TDO, PARALLEL_OUT}, 2'h1)
    tap.ctl(1'b0, 1'b1);
    `CHK({HELD_CONTROL_BIT, PARALLEL_OUT}, 2'h0)
    tap.step(1'b1, 1'b1, 1'b1);
    `CHK({HELD_CONTROL_BIT, PARALLEL_OUT}, 2'h3)
    tap.ctl(1'b1, 1'b1);
    tap.step(1'b1, 1'b1, 1'b0);
    `CHK({TDO, HELD_CONTROL_BIT}, 2'h1)
    @(posedge CLK);
    MODE <= 1'b0;
    #1;
    `CHK(PARALLEL_OUT, 1'b1)
    repeat (3) @(posedge CLK);
    rd(STATUS_OFS, d);
    `CHK(d, 32'h1)
    wr(CTRL_OFS, 32'h0);
    `CHK(PARALLEL_OUT, 1'b0)
  endtask
  initial begin
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    t_parallel();
    // The test clock side leaves reset only some cycles after the system.
    repeat (30) @(posedge CLK);
    t_shift();
    t_capture();
    t_chain();
    report_and_stop();
  end
endmodule
